// >>> hw/amr_pkg.sv
// Constants for the ARP/RARP frame rule matcher.
// Assumes a 32-bit Avalon-MM register bus with word addressing.
package amr_pkg;
  // ==========================================================
  // Register word indices
  localparam logic [3:0] AMR_REG_CTRL = 4'h0;
  localparam logic [3:0] AMR_REG_SPA = 4'h1;
  localparam logic [3:0] AMR_REG_SPA_MASK = 4'h2;
  localparam logic [3:0] AMR_REG_TPA = 4'h3;
  localparam logic [3:0] AMR_REG_TPA_MASK = 4'h4;
  localparam logic [3:0] AMR_REG_HIT_COUNT = 4'h5;
  localparam logic [3:0] AMR_REG_IRQ_STATUS = 4'h6;
  localparam logic [3:0] AMR_REG_IRQ_MASK = 4'h7;

  // ==========================================================
  // Control register field positions (low bit of each field)
  localparam int AMR_F_FTYPE = 0;
  localparam int AMR_F_DENY = 2;
  localparam int AMR_F_OPCLASS = 3;
  localparam int AMR_F_REQREP = 5;
  localparam int AMR_F_SPA_SEL = 7;
  localparam int AMR_F_TPA_SEL = 9;
  localparam int AMR_F_SHA_CHK = 11;
  localparam int AMR_F_THA_CHK = 13;
  localparam int AMR_F_LEN_CHK = 15;
  localparam int AMR_F_HRD_CHK = 17;
  localparam int AMR_F_PRO_CHK = 19;
  localparam int AMR_CTRL_BITS = 21;
  localparam logic [31:0] AMR_CTRL_RESET = 32'h0000_0000;

  // ==========================================================
  // Interrupt status bits
  localparam int AMR_IRQ_HIT = 0;
  localparam int AMR_IRQ_DENY = 1;
  localparam int AMR_IRQ_BITS = 2;

  // ==========================================================
  // Selector encodings
  typedef enum logic [1:0] {
    AMR_FT_ANY = 2'h0, AMR_FT_ETYPE = 2'h1, AMR_FT_ARP = 2'h2, AMR_FT_IPV4 = 2'h3
  } amr_ftype_t;
  typedef enum logic [1:0] {
    AMR_OC_ANY = 2'h0, AMR_OC_ARP = 2'h1, AMR_OC_RARP = 2'h2, AMR_OC_OTHER = 2'h3
  } amr_opclass_t;
  typedef enum logic [1:0] {
    AMR_RR_ANY = 2'h0, AMR_RR_REQ = 2'h1, AMR_RR_REPLY = 2'h2
  } amr_reqrep_t;
  typedef enum logic [1:0] {
    AMR_AS_ANY = 2'h0, AMR_AS_HOST = 2'h1, AMR_AS_NET = 2'h2
  } amr_addrsel_t;
  // Three-way check: 0 requires false, 1 requires true, 2 or 3 ignore
  localparam logic [1:0] AMR_TRI_ZERO = 2'h0;
  localparam logic [1:0] AMR_TRI_ONE = 2'h1;

  // ==========================================================
  // Frame field values
  localparam logic [15:0] AMR_OP_ARP_REQ = 16'h0001;
  localparam logic [15:0] AMR_OP_ARP_REPLY = 16'h0002;
  localparam logic [15:0] AMR_OP_RARP_REQ = 16'h0003;
  localparam logic [15:0] AMR_OP_RARP_REPLY = 16'h0004;
  localparam logic [7:0] AMR_HW_LEN_ETH = 8'h06;
  localparam logic [7:0] AMR_PROTO_LEN_IPV4 = 8'h04;
  localparam logic [15:0] AMR_HW_SPACE_ETH = 16'h0001;
  localparam logic [15:0] AMR_PROTO_SPACE_IP = 16'h0800;
endpackage

// >>> hw/amr_matcher.sv
// ARP/RARP rule matcher for one access_control_entry, with Avalon-MM
// register slave, hit counter and interrupt. Frame fields arrive from
// the ingress parser on mclk, one frame per frame_valid pulse.
//
// Functional notes
// R1: ARP-specific checks apply only when the entry frame type is ARP.
// R2: Opcode class selector: any, ARP opcode, RARP opcode, or neither.
// R3: Direction selector: request opcodes, reply opcodes, or any.
// R4: Sender address Host mode: exact 32-bit equality with configured address.
// R5: Sender address Network mode: compare only bits set in sender mask.
// R6: Target address Host mode: exact equality with configured target address.
// R7: Target address Network mode: compare only under target mask.
// R8: Address selector Any: that comparison always passes.
// R9: ARP sender hardware address vs source MAC: 1 equal, 0 unequal, Any ignore.
// R10: RARP target hardware address vs source MAC: 1 equal, 0 unequal, Any ignore.
// R11: Lengths 6 and 4 test: 1 requires, 0 excludes, Any ignores.
// R12: Hardware space equals Ethernet 1: 1 requires, 0 excludes, Any ignores.
// R13: Protocol space equals 0x800: 1 requires, 0 excludes, Any ignores.
// R14: Hit counter increments on every frame hitting the entry.
// R15: Hit with deny action discards the frame; permit lets it through.
// R16: Hit only when all enabled checks pass together.
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ns
module amr_matcher
  import amr_pkg::*;
#(
  parameter int CNT_W = 32
) (
  input wire logic mclk, // 250 MHz core clock
  input wire logic reset, // Synchronous, active high
  // Avalon-MM slave
  input wire logic [3:0] avs_address, // Word index
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic irq, // Level interrupt
  // Parser side
  input wire logic frame_valid, // One pulse per frame
  input wire logic [1:0] frame_kind, // Frame type, amr_ftype_t code
  input wire logic [15:0] frame_opcode, // ARP operation
  input wire logic [47:0] source_hw_address, // Ethernet source MAC
  input wire logic [47:0] frame_sha, // Sender hardware address
  input wire logic [47:0] frame_tha, // Target hardware address
  input wire logic [31:0] sender_proto_address, // Sender protocol address
  input wire logic [31:0] frame_tpa, // Target protocol address
  input wire logic [7:0] frame_hw_len, // Hardware address length
  input wire logic [7:0] frame_proto_len, // Protocol address length
  input wire logic [15:0] frame_hw_space, // Hardware address space
  input wire logic [15:0] frame_proto_space, // Protocol address space
  output logic frame_hit, // Pulse: frame hit the entry
  output logic frame_permit, // Pulse: hit, forward
  output logic frame_discard // Pulse: hit, drop
);

  // ==========================================================
  // Register storage
  logic [AMR_CTRL_BITS-1:0] ctrl;
  logic [31:0] spa_cfg;
  logic [31:0] spa_mask;
  logic [31:0] tpa_cfg;
  logic [31:0] tpa_mask;
  logic [CNT_W-1:0] hit_count;
  logic [AMR_IRQ_BITS-1:0] irq_status;
  logic [AMR_IRQ_BITS-1:0] irq_mask;
  logic bus_ack;
  logic [31:0] be_mask;
  logic wr_fire;
  logic rd_fire;

  // Byte lanes expanded into a bit mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_be
      assign be_mask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // ==========================================================
  // Bus handshake: every access takes exactly one wait cycle.
  // Reads load in the first cycle so data stands while waitrequest is low;
  // writes land only at the edge that completes the transfer, so a stalled
  // master never sees a register change before its access is accepted.
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
  assign wr_fire = avs_write & bus_ack;
  assign rd_fire = avs_read & ~bus_ack;

  always_ff @(posedge mclk) begin
    if (reset) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= (avs_read | avs_write) & ~bus_ack;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_fire) begin
      case (avs_address)
        AMR_REG_CTRL: avs_readdata <= 32'(ctrl);
        AMR_REG_SPA: avs_readdata <= spa_cfg;
        AMR_REG_SPA_MASK: avs_readdata <= spa_mask;
        AMR_REG_TPA: avs_readdata <= tpa_cfg;
        AMR_REG_TPA_MASK: avs_readdata <= tpa_mask;
        AMR_REG_HIT_COUNT: avs_readdata <= 32'(hit_count);
        AMR_REG_IRQ_STATUS: avs_readdata <= 32'(irq_status);
        AMR_REG_IRQ_MASK: avs_readdata <= 32'(irq_mask);
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl <= AMR_CTRL_RESET[AMR_CTRL_BITS-1:0];
      spa_cfg <= 32'h0000_0000;
      spa_mask <= 32'h0000_0000;
      tpa_cfg <= 32'h0000_0000;
      tpa_mask <= 32'h0000_0000;
      irq_mask <= '0;
    end else if (wr_fire) begin
      case (avs_address)
        AMR_REG_CTRL: ctrl <= AMR_CTRL_BITS'(merge(32'(ctrl), avs_writedata, be_mask));
        AMR_REG_SPA: spa_cfg <= merge(spa_cfg, avs_writedata, be_mask);
        AMR_REG_SPA_MASK: spa_mask <= merge(spa_mask, avs_writedata, be_mask);
        AMR_REG_TPA: tpa_cfg <= merge(tpa_cfg, avs_writedata, be_mask);
        AMR_REG_TPA_MASK: tpa_mask <= merge(tpa_mask, avs_writedata, be_mask);
        AMR_REG_IRQ_MASK: irq_mask <= AMR_IRQ_BITS'(merge(32'(irq_mask), avs_writedata, be_mask));
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Field decode
  // Spare selector codes act as Any, so a partly written entry errs
  // towards matching rather than silently dropping traffic.
  logic [1:0] sel_ftype;
  logic act_deny;
  logic [1:0] sel_opclass;
  logic [1:0] sel_reqrep;
  logic [1:0] sel_spa;
  logic [1:0] sel_tpa;
  logic [1:0] chk_sha;
  logic [1:0] chk_tha;
  logic [1:0] chk_len;
  logic [1:0] chk_hrd;
  logic [1:0] chk_pro;

  assign sel_ftype = ctrl[AMR_F_FTYPE +: 2];
  assign act_deny = ctrl[AMR_F_DENY];
  assign sel_opclass = ctrl[AMR_F_OPCLASS +: 2];
  assign sel_reqrep = ctrl[AMR_F_REQREP +: 2];
  assign sel_spa = ctrl[AMR_F_SPA_SEL +: 2];
  assign sel_tpa = ctrl[AMR_F_TPA_SEL +: 2];
  assign chk_sha = ctrl[AMR_F_SHA_CHK +: 2];
  assign chk_tha = ctrl[AMR_F_THA_CHK +: 2];
  assign chk_len = ctrl[AMR_F_LEN_CHK +: 2];
  assign chk_hrd = ctrl[AMR_F_HRD_CHK +: 2];
  assign chk_pro = ctrl[AMR_F_PRO_CHK +: 2];

  // Three-way check against a frame condition; codes 2 and 3 ignore it
  function automatic logic tri_ok(input logic [1:0] sel, input logic cond);
    case (sel)
      AMR_TRI_ZERO: tri_ok = ~cond;
      AMR_TRI_ONE: tri_ok = cond;
      default: tri_ok = 1'b1;
    endcase
  endfunction

  // Host compares all bits, Network only the masked ones, Any passes
  function automatic logic addr_ok(input logic [1:0] sel, input logic [31:0] got,
                                   input logic [31:0] cfg, input logic [31:0] m);
    case (sel)
      AMR_AS_HOST: addr_ok = (got == cfg); // [R4] [R6]
      AMR_AS_NET: addr_ok = ((got ^ cfg) & m) == 32'h0000_0000; // [R5] [R7]
      default: addr_ok = 1'b1; // [R8]
    endcase
  endfunction

  // ==========================================================
  // Match logic
  logic op_is_arp;
  logic op_is_rarp;
  logic op_is_req;
  logic op_is_reply;
  logic type_ok;
  logic opclass_ok;
  logic reqrep_ok;
  logic arp_ok;
  logic match;

  assign op_is_arp = (frame_opcode == AMR_OP_ARP_REQ) | (frame_opcode == AMR_OP_ARP_REPLY);
  assign op_is_rarp = (frame_opcode == AMR_OP_RARP_REQ) | (frame_opcode == AMR_OP_RARP_REPLY);
  assign op_is_req = (frame_opcode == AMR_OP_ARP_REQ) | (frame_opcode == AMR_OP_RARP_REQ);
  assign op_is_reply = (frame_opcode == AMR_OP_ARP_REPLY) | (frame_opcode == AMR_OP_RARP_REPLY);

  assign type_ok = (sel_ftype == AMR_FT_ANY) | (frame_kind == sel_ftype);

  always_comb begin
    case (sel_opclass)
      AMR_OC_ARP: opclass_ok = op_is_arp; // [R2]
      AMR_OC_RARP: opclass_ok = op_is_rarp; // [R2]
      AMR_OC_OTHER: opclass_ok = ~op_is_arp & ~op_is_rarp; // [R2]
      default: opclass_ok = 1'b1; // [R2]
    endcase
  end

  always_comb begin
    case (sel_reqrep)
      AMR_RR_REQ: reqrep_ok = op_is_req; // [R3]
      AMR_RR_REPLY: reqrep_ok = op_is_reply; // [R3]
      default: reqrep_ok = 1'b1; // [R3]
    endcase
  end

  logic spa_ok;
  logic tpa_ok;
  logic sha_ok;
  logic tha_ok;
  logic len_ok;
  logic hrd_ok;
  logic pro_ok;

  assign spa_ok = addr_ok(sel_spa, sender_proto_address, spa_cfg, spa_mask); // [R4] [R5] [R8]
  assign tpa_ok = addr_ok(sel_tpa, frame_tpa, tpa_cfg, tpa_mask); // [R6] [R7] [R8]
  // Hardware address checks only consider frames of the matching opcode
  // family; other opcodes pass, since the check speaks of those frames only.
  assign sha_ok = ~op_is_arp | tri_ok(chk_sha, frame_sha == source_hw_address); // [R9]
  assign tha_ok = ~op_is_rarp | tri_ok(chk_tha, frame_tha == source_hw_address); // [R10]
  assign len_ok = tri_ok(chk_len, (frame_hw_len == AMR_HW_LEN_ETH)
                                & (frame_proto_len == AMR_PROTO_LEN_IPV4)); // [R11]
  assign hrd_ok = tri_ok(chk_hrd, frame_hw_space == AMR_HW_SPACE_ETH); // [R12]
  assign pro_ok = tri_ok(chk_pro, frame_proto_space == AMR_PROTO_SPACE_IP); // [R13]

  // Every enabled check must pass at once
  assign arp_ok = opclass_ok & reqrep_ok & spa_ok & tpa_ok & sha_ok & tha_ok
                & len_ok & hrd_ok & pro_ok; // [R16]

  // ARP settings are ignored unless the entry is an ARP entry
  assign match = type_ok & ((sel_ftype != AMR_FT_ARP) | arp_ok); // [R1] [R16]

  // ==========================================================
  // Verdict, one cycle after the frame pulse
  // Registered so the forwarding logic downstream sees clean one-cycle
  // strobes, at the cost of one cycle of latency.
  always_ff @(posedge mclk) begin
    if (reset) begin
      frame_hit <= 1'b0;
      frame_permit <= 1'b0;
      frame_discard <= 1'b0;
    end else begin
      frame_hit <= frame_valid & match; // [R16]
      frame_permit <= frame_valid & match & ~act_deny; // [R15]
      frame_discard <= frame_valid & match & act_deny; // [R15]
    end
  end

  // ==========================================================
  // Hit counter: any write to it clears it, but a hit in the same cycle
  // still counts so no hit is lost. Wraps at full scale.
  always_ff @(posedge mclk) begin
    if (reset) begin
      hit_count <= '0;
    end else if (wr_fire && avs_address == AMR_REG_HIT_COUNT) begin
      hit_count <= CNT_W'(frame_valid & match); // [R14]
    end else if (frame_valid & match) begin
      hit_count <= hit_count + CNT_W'(1); // [R14]
    end
  end

  // ==========================================================
  // Interrupt status: sticky, write one to clear, new event wins
  // A hit and a clear of the same bit in one cycle leave the bit set,
  // so software never loses an event it has not yet seen.
  logic [AMR_IRQ_BITS-1:0] irq_event;
  logic [AMR_IRQ_BITS-1:0] irq_clear;

  assign irq_event = {frame_valid & match & act_deny, frame_valid & match};
  assign irq_clear = (wr_fire && avs_address == AMR_REG_IRQ_STATUS)
                   ? (avs_writedata[AMR_IRQ_BITS-1:0] & be_mask[AMR_IRQ_BITS-1:0])
                   : '0;

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end

  assign irq = |(irq_status & irq_mask);

endmodule

// >>> verif/amr_matcher_props.sv
// Checker: bus timing, outcome pulses, irq cause.
// Bound into amr_matcher; one clock, sync reset.
`timescale 1ns/1ns
module amr_matcher_props
  import amr_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic reset, // reset
  input wire logic [3:0] avs_address, // index
  input wire logic avs_read, // read
  input wire logic avs_write, // write
  input wire logic [31:0] avs_readdata, // data
  input wire logic avs_waitrequest, // stall
  input wire logic irq, // interrupt
  input wire logic frame_valid, // strobe
  input wire logic frame_hit, // hit
  input wire logic frame_permit, // forward
  input wire logic frame_discard // drop
);
  // ==========
  // Properties
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  wire rd_done = avs_read && !avs_waitrequest;
  a_hit_follows_frame: assert property (frame_hit |-> $past(frame_valid))
    else $error("hit without frame");
  a_outcome_split: assert property (frame_hit |-> frame_permit != frame_discard)
    else $error("bad outcome");
  a_no_stray_drop: assert property (!frame_hit |-> !frame_permit && !frame_discard)
    else $error("outcome without hit");
  a_one_wait_state: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait state count");
  a_idle_no_stall: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("stall while idle");
  a_ctrl_top_zero: assert property (rd_done && avs_address == AMR_REG_CTRL |-> avs_readdata[31:21] == '0)
    else $error("ctrl upper bits");
  a_unmapped_zero: assert property (rd_done && avs_address[3] |-> avs_readdata == 32'h0)
    else $error("unmapped read");
  a_irq_has_cause: assert property ($rose(irq) |-> frame_hit || $past(avs_write))
    else $error("irq without cause");
  c_deny_hit: cover property (frame_discard);
  c_permit_hit: cover property (frame_permit);
  c_irq_up: cover property ($rose(irq));
endmodule

// >>> verif/amr_parser_model.sv
// Ingress parser stand-in: one parsed frame per send call.
// Matcher takes all fields at the edge where frame_valid is high.
`timescale 1ns/1ns
module amr_parser_model
  import amr_pkg::*;
(
  input wire logic mclk, // clock
  output logic frame_valid, // strobe
  output logic [1:0] frame_kind, // type
  output logic [15:0] frame_opcode, // op
  output logic [47:0] source_hw_address, // mac
  output logic [47:0] frame_sha, // sha
  output logic [47:0] frame_tha, // tha
  output logic [31:0] sender_proto_address, // spa
  output logic [31:0] frame_tpa, // tpa
  output logic [7:0] frame_hw_len, // hlen
  output logic [7:0] frame_proto_len, // plen
  output logic [15:0] frame_hw_space, // hrd
  output logic [15:0] frame_proto_space // pro
);
  logic [273:0] fields = '0;
  initial frame_valid = 1'b0;
  assign {frame_kind, frame_opcode, source_hw_address, frame_sha, frame_tha, sender_proto_address,
    frame_tpa, frame_hw_len, frame_proto_len, frame_hw_space, frame_proto_space} = fields;
  // Inverted after the strobe so a stale frame never looks valid
  task automatic send(input logic [273:0] f);
    @(posedge mclk);
    frame_valid <= 1'b1;
    fields <= f;
    @(posedge mclk);
    frame_valid <= 1'b0;
    fields <= ~fields;
  endtask
endmodule

// >>> verif/testbench.sv
// Bench: register and frame tasks, table-driven cases.
// Needs package, matcher, parser model and checker.
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("wrong value at %0t: got %h want %h", $time, got, exp); \
    end \
  end
module testbench
  import amr_pkg::*;
;
  localparam logic [47:0] SOURCE_HW_ADDRESS = 48'h0200_0000_0001;
  logic mclk, reset, avs_read, avs_write, avs_waitrequest, irq, deny;
  logic frame_valid, frame_hit, frame_permit, frame_discard;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, v, f_spa, f_tpa, sender_proto_address, frame_tpa;
  logic [1:0] frame_kind, f_kind;
  logic [15:0] frame_opcode, frame_hw_space, frame_proto_space, f_op, f_hs, f_ps;
  logic [47:0] source_hw_address, frame_sha, frame_tha, f_sha, f_tha;
  logic [7:0] frame_hw_len, frame_proto_len, f_hl;
  int err_count = 0;
  int comparisons = 0;
  int hits = 0;
  amr_matcher i_dut (.mclk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .irq, .frame_valid, .frame_kind,
    .frame_opcode, .source_hw_address, .frame_sha, .frame_tha, .sender_proto_address, .frame_tpa,
    .frame_hw_len, .frame_proto_len, .frame_hw_space, .frame_proto_space, .frame_hit, .frame_permit,
    .frame_discard);
  amr_parser_model i_parser (.mclk, .frame_valid, .frame_kind, .frame_opcode, .source_hw_address,
    .frame_sha, .frame_tha, .sender_proto_address, .frame_tpa, .frame_hw_len, .frame_proto_len,
    .frame_hw_space, .frame_proto_space);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic close_out();
    if (err_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // Waitrequest is sampled at the edge itself, before the slave updates
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (n == 20) begin
      err_count++;
      close_out();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic set(input logic [1:0] ft, oc, rr, ss, ts, input logic [9:0] tc);
    bus(1'b1, AMR_REG_CTRL, {11'h0, tc, ts, ss, rr, oc, deny, ft});
  endtask
  task automatic dflt();
    f_kind = 2'h2;
    f_op = 16'h0001;
    f_sha = SOURCE_HW_ADDRESS;
    f_tha = SOURCE_HW_ADDRESS;
    f_spa = 32'hC0A8_0105;
    f_tpa = 32'hC0A8_0101;
    f_hl = 8'h06;
    f_hs = 16'h0001;
    f_ps = 16'h0800;
  endtask
  // Frame goes out, outcome is judged in the cycle after it is taken
  task automatic go(input logic exp);
    i_parser.send({f_kind, f_op, SOURCE_HW_ADDRESS, f_sha, f_tha, f_spa, f_tpa, f_hl, 8'h04, f_hs, f_ps});
    #1;
    `CHK({frame_hit, frame_permit, frame_discard}, {exp, exp & !deny, exp & deny})
    hits += exp;
  endtask
  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    deny = 1'b0;
    dflt();
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    bus(1'b0, AMR_REG_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b1, AMR_REG_SPA, 32'hC0A8_0105);
    bus(1'b1, AMR_REG_SPA_MASK, 32'hFFFF_FF00);
    bus(1'b1, AMR_REG_TPA, 32'hC0A8_0101);
    bus(1'b1, AMR_REG_TPA_MASK, 32'hFFFF_FF00);
    set(2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 10'h2AA);
    go(1'b1);
    f_kind = 2'h3;
    go(1'b0);
    set(2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 10'h000);
    go(1'b1);
    dflt();
    for (int oc = 0; oc < 4; oc++) begin
      for (int rr = 0; rr < 3; rr++) begin
        set(2'h2, oc[1:0], rr[1:0], 2'h0, 2'h0, 10'h2AA);
        for (int op = 1; op < 6; op++) begin
          f_op = 16'(op);
          go((oc == 0 || oc == 1 && op < 3 || oc == 2 && (op == 3 || op == 4) || oc == 3 && op == 5)
            && (rr == 0 || rr == 1 && op % 2 == 1 && op < 5 || rr == 2 && op % 2 == 0));
        end
      end
    end
    for (int w = 0; w < 2; w++) begin
      for (int s = 0; s < 3; s++) begin
        set(2'h2, 2'h0, 2'h0, w ? 2'h0 : s[1:0], w ? s[1:0] : 2'h0, 10'h2AA);
        for (int i = 0; i < 3; i++) begin
          dflt();
          v = i[1] ? 32'h100 : 32'(i);
          f_spa = w ? f_spa : f_spa ^ v;
          f_tpa = w ? f_tpa ^ v : f_tpa;
          go(s == 0 || i == 0 || s == 2 && i == 1);
        end
      end
    end
    for (int f = 0; f < 5; f++) begin
      for (int c = 0; c < 3; c++) begin
        set(2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 10'h2AA & ~(10'h3 << 2 * f) | 10'(c << 2 * f));
        for (int t = 0; t < 2; t++) begin
          dflt();
          f_op = f == 1 ? 16'h0003 : 16'h0001;
          if (t == 0) begin
            case (f)
              0: f_sha = ~SOURCE_HW_ADDRESS;
              1: f_tha = ~SOURCE_HW_ADDRESS;
              2: f_hl = 8'h08;
              3: f_hs = 16'h0006;
              default: f_ps = 16'h86DD;
            endcase
          end
          go(c == 2 || c == t);
        end
      end
    end
    deny = 1'b1;
    dflt();
    set(2'h2, 2'h1, 2'h1, 2'h1, 2'h2, 10'h2AA);
    go(1'b1);
    f_op = 16'h0002;
    go(1'b0);
    deny = 1'b0;
    bus(1'b0, AMR_REG_HIT_COUNT, 32'h0);
    `CHK(rd, 32'(hits))
    bus(1'b1, AMR_REG_HIT_COUNT, 32'h0);
    bus(1'b0, AMR_REG_HIT_COUNT, 32'h0);
    `CHK(rd, 32'h0)
    bus(1'b0, AMR_REG_IRQ_STATUS, 32'h0);
    `CHK({rd, irq}, {32'h3, 1'b0})
    bus(1'b1, AMR_REG_IRQ_MASK, 32'h2);
    #1;
    `CHK(irq, 1'b1)
    bus(1'b1, AMR_REG_IRQ_STATUS, 32'h2);
    bus(1'b0, AMR_REG_IRQ_STATUS, 32'h0);
    `CHK({rd, irq}, {32'h1, 1'b0})
    bus(1'b0, 4'h9, 32'h0);
    `CHK(rd, 32'h0)
    close_out();
  end
endmodule
bind amr_matcher amr_matcher_props i_props (.mclk, .reset, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .irq, .frame_valid, .frame_hit, .frame_permit, .frame_discard);
